// ### adc_cmd_device.sv
// Converter end of the serial link: command decoder, register file and readout.
//
// Summary of operation
// - wake, sleep, soft reset decoded, bit 0 ignored.
// - synchronise is two matching bytes, acted on pair.
// - read once, start, stop continuous decoded.
// - register read/write carry address, then count byte.
// - calibrations decoded at 60h, 61h, 62h.
// - host never sends restricted byte F1h.
// - wake takes effect at eighth rising edge.
// - sleep after current conversion; only wake exits.
// - synchronise restarts filter and conversion.
// - soft reset restores registers, keeps interface state.
// - soft reset holds logic for 0.6 ms.
// - power-up holds logic for 2^16 cycles.
// - continuous mode loads each result at ready.
// - continuous mode starts at the following ready.
// - host finishes readout before next ready fall.
// - stop takes effect at next ready; no reloads.
// - read once loads latest result, any mode.
// - read once accepted during last result byte.
// - register read outputs count+1 bytes, address wraps.
// - input bytes ignored during register readout.
// - register write stores count+1 consecutive bytes.
// - calibration end updates offset or gain coefficient.
`timescale 1ns/1ps
`default_nettype none
module adc_cmd_device
  import adc_cmd_pkg::*;
#(
  parameter int HOLD_POWERUP = POWERUP_CYCLES_DEFAULT,
  parameter int HOLD_SOFT    = SOFT_RESET_CYCLES_DEFAULT
) (
  input  wire logic                       i_clk,
  input  wire logic                       i_srst,
  adc_link_if.device                      lnk,
  input  wire logic                       i_result_valid,
  input  wire logic [RESULT_BITS-1:0]     i_result,
  input  wire logic                       i_cal_done,
  input  wire logic [RESULT_BITS-1:0]     i_cal_coeff,
  output logic                            o_sleep,
  output logic                            o_filter_restart,
  output logic                            o_reset_hold,
  output logic                            o_cal_start,
  output logic [1:0]                      o_cal_kind,
  output logic                            o_continuous,
  output logic [REG_COUNT*8-1:0]          o_reg_file
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (HOLD_POWERUP < 1 || HOLD_POWERUP >= 2 ** HOLD_W) begin : g_bad_powerup
    $error("HOLD_POWERUP out of range");
  end
  if (HOLD_SOFT < 1 || HOLD_SOFT >= 2 ** HOLD_W) begin : g_bad_soft
    $error("HOLD_SOFT out of range");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PH_CMD, PH_SYNC2, PH_RCOUNT, PH_WCOUNT, PH_WDATA, PH_RDATA
  } dev_phase_t;

  typedef struct packed {
    dev_phase_t                 phase;
    logic [2:0]                 bitcnt;
    logic [7:0]                 rx;
    logic [RESULT_BITS-1:0]     tx;
    logic                       load_reg;
    logic                       load_res;
    logic [3:0]                 addr;
    logic [3:0]                 count;
    logic [REG_COUNT-1:0][7:0]  regs;
    logic [RESULT_BITS-1:0]     latest;
    logic                       sleep;
    logic                       sleep_pend;
    logic                       cont;
    logic                       cont_on_pend;
    logic                       cont_off_pend;
    logic                       rdy_n;
    logic                       restart;
    logic                       cal_start;
    cal_kind_t                  cal_kind;
    logic [HOLD_W-1:0]          hold;
    logic                       sclk_prev;
  } dev_state_t;

  dev_state_t s;
  dev_state_t n;
  logic [2:0] pins_s;
  logic       sclk_s;
  logic       cs_n_s;
  logic       mosi_s;
  logic       rise;
  logic       fall;

  // Bring the link pins into the clock domain.
  link_sync #(.WIDTH(3), .RST_VAL(3'h3)) u_sync (
    .i_clk  (i_clk),
    .i_srst (i_srst),
    .i_d    ({lnk.sclk, lnk.cs_n, lnk.mosi}),
    .o_q    (pins_s)
  );

  // Edge detection on the synchronised serial clock.
  assign sclk_s = pins_s[2];
  assign cs_n_s = pins_s[1];
  assign mosi_s = pins_s[0];
  assign rise   = sclk_s & ~s.sclk_prev;
  assign fall   = ~sclk_s & s.sclk_prev;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0] rx_byte;
    cmd_t       cmd;
    logic [3:0] base;
    rx_byte = {s.rx[6:0], mosi_s};
    cmd     = decode_command(rx_byte);
    base    = GAIN_REG_BASE;
    n = s;
    n.sclk_prev = sclk_s;
    n.restart   = 1'b0;
    n.cal_start = 1'b0;
    if (i_srst) begin
      n = '0;
      n.phase = PH_CMD;
      n.cont  = 1'b1;
      n.rdy_n = 1'b1;
      n.hold  = HOLD_W'(HOLD_POWERUP);
      n.regs  = {REG_COUNT{REG_RESET_VALUE}};
      n.cal_kind = CAL_SYS_OFFSET;
    end else if (s.hold != '0) begin
      // Registers and filter held; link and converter are ignored.
      n.hold = s.hold - 1'b1;
    end else begin
      // Finished calibration writes its coefficient, low byte first.
      if (i_cal_done) begin
        base = (s.cal_kind == CAL_SYS_GAIN) ? GAIN_REG_BASE : OFFSET_REG_BASE;
        for (int i = 0; i < 3; i++) begin
          n.regs[base + 4'(i)] = i_cal_coeff[8*i +: 8];
        end
      end
      if (cs_n_s) begin
        // Chip select high realigns the interface.
        n.bitcnt   = 3'd0;
        n.phase    = PH_CMD;
        n.load_reg = 1'b0;
        n.load_res = 1'b0;
      end else if (rise) begin
        n.rx     = rx_byte;
        n.bitcnt = s.bitcnt + 3'd1;
        n.rdy_n  = 1'b1;
        if (s.bitcnt == 3'd7) begin
          case (s.phase)
            PH_CMD: begin
              case (cmd)
                CMD_WAKE: begin
                  n.sleep      = 1'b0;
                  n.sleep_pend = 1'b0;
                end
                CMD_SLEEP: n.sleep_pend = 1'b1;
                CMD_SYNC: n.phase = PH_SYNC2;
                CMD_RESET: begin
                  n.regs = {REG_COUNT{REG_RESET_VALUE}};
                  n.hold = HOLD_W'(HOLD_SOFT);
                end
                CMD_READ_ONCE: n.load_res = 1'b1;
                CMD_READ_CONT: begin
                  n.cont_on_pend  = 1'b1;
                  n.cont_off_pend = 1'b0;
                end
                CMD_STOP_CONT: begin
                  n.cont_off_pend = 1'b1;
                  n.cont_on_pend  = 1'b0;
                end
                CMD_REG_READ: begin
                  n.addr  = rx_byte[3:0];
                  n.phase = PH_RCOUNT;
                end
                CMD_REG_WRITE: begin
                  n.addr  = rx_byte[3:0];
                  n.phase = PH_WCOUNT;
                end
                CMD_CAL_SYS_OFS: begin
                  n.cal_start = 1'b1;
                  n.cal_kind  = CAL_SYS_OFFSET;
                end
                CMD_CAL_SYS_GAIN: begin
                  n.cal_start = 1'b1;
                  n.cal_kind  = CAL_SYS_GAIN;
                end
                CMD_CAL_SELF_OFS: begin
                  n.cal_start = 1'b1;
                  n.cal_kind  = CAL_SELF_OFFSET;
                end
                default: n.phase = PH_CMD;
              endcase
            end
            PH_SYNC2: begin
              // Only a matching second byte restarts the conversion.
              n.restart = (rx_byte[7:1] == OP_SYNC);
              n.phase   = PH_CMD;
            end
            PH_RCOUNT: begin
              n.count    = rx_byte[3:0];
              n.load_reg = 1'b1;
              n.phase    = PH_RDATA;
            end
            PH_WCOUNT: begin
              n.count = rx_byte[3:0];
              n.phase = PH_WDATA;
            end
            PH_WDATA: begin
              n.regs[s.addr] = rx_byte;
              n.addr = s.addr + 4'd1;
              n.count = s.count - 4'd1;
              if (s.count == 4'd0) n.phase = PH_CMD;
            end
            PH_RDATA: begin
              // Incoming byte is dropped; advance to the next register.
              n.addr = s.addr + 4'd1;
              n.count = s.count - 4'd1;
              if (s.count == 4'd0) n.phase = PH_CMD;
              else n.load_reg = 1'b1;
            end
            default: n.phase = PH_CMD;
          endcase
        end
      end else if (fall) begin
        // Loads happen on the falling edge after a byte, otherwise shift.
        if (s.bitcnt == 3'd0 && s.load_reg) begin
          n.tx = {s.regs[s.addr], 16'h0000};
        end else if (s.bitcnt == 3'd0 && s.load_res) begin
          n.tx = s.latest;
        end else begin
          n.tx = {s.tx[RESULT_BITS-2:0], 1'b0};
        end
        if (s.bitcnt == 3'd0) begin
          n.load_reg = 1'b0;
          n.load_res = 1'b0;
        end
      end
      // New result: apply pending mode changes, then reload in continuous mode.
      if (i_result_valid) begin
        n.latest = i_result;
        n.rdy_n  = 1'b0;
        if (s.sleep_pend) n.sleep = 1'b1;
        n.sleep_pend = 1'b0;
        if (s.cont_on_pend) n.cont = 1'b1;
        if (s.cont_off_pend) n.cont = 1'b0;
        n.cont_on_pend  = 1'b0;
        n.cont_off_pend = 1'b0;
        if (n.cont) n.tx = i_result;
      end
    end
  end

  // Register the state.
  always_ff @(posedge i_clk) begin
    s <= n;
  end

  // Outputs straight from the state flops; reset hold is decoded from a nonzero hold count.
  assign lnk.miso               = s.tx[RESULT_BITS-1];
  assign lnk.conversion_ready_n = s.rdy_n;
  assign o_sleep                = s.sleep;
  assign o_filter_restart       = s.restart;
  assign o_reset_hold           = (s.hold != '0);
  assign o_cal_start            = s.cal_start;
  assign o_cal_kind             = s.cal_kind;
  assign o_continuous           = s.cont;
  assign o_reg_file             = s.regs;

endmodule
`default_nettype wire

// ### adc_cmd_pkg.sv
// Shared constants, command codes and decoder for the converter serial command link.
package adc_cmd_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS             = 25;
  localparam int POWERUP_CYCLES_DEFAULT    = 65536;
  localparam int SOFT_RESET_TIME_NS        = 600000;
  localparam int SOFT_RESET_CYCLES_DEFAULT =
    (SOFT_RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCLK_HALF_CYCLES_DEFAULT  = 8;
  localparam int HOLD_W                    = 17;

  // ----------------------------------------------------------------
  // Data and register layout
  // ----------------------------------------------------------------
  localparam int          RESULT_BITS     = 24;
  localparam int          REG_COUNT       = 16;
  localparam logic [7:0]  REG_RESET_VALUE = 8'h00;
  localparam logic [3:0]  OFFSET_REG_BASE = 4'h4;
  localparam logic [3:0]  GAIN_REG_BASE   = 4'h7;

  // ----------------------------------------------------------------
  // Command codes (upper seven bits where bit 0 is ignored, upper four for register access, else the whole byte)
  // ----------------------------------------------------------------
  localparam logic [6:0] OP_WAKE       = 7'h00;
  localparam logic [6:0] OP_SLEEP      = 7'h01;
  localparam logic [6:0] OP_SYNC       = 7'h02;
  localparam logic [6:0] OP_RESET      = 7'h03;
  localparam logic [6:0] OP_READ_ONCE  = 7'h09;
  localparam logic [6:0] OP_READ_CONT  = 7'h0A;
  localparam logic [6:0] OP_STOP_CONT  = 7'h0B;
  localparam logic [3:0] OP_REG_READ   = 4'h2;
  localparam logic [3:0] OP_REG_WRITE  = 4'h4;
  localparam logic [7:0] OP_CAL_SYS_OFS  = 8'h60;
  localparam logic [7:0] OP_CAL_SYS_GAIN = 8'h61;
  localparam logic [7:0] OP_CAL_SELF_OFS = 8'h62;
  localparam logic [7:0] OP_RESTRICTED   = 8'hF1;
  localparam logic [7:0] NO_OPERATION_BYTE = 8'hFF;

  typedef enum logic [3:0] {
    CMD_WAKE, CMD_SLEEP, CMD_SYNC, CMD_RESET, CMD_READ_ONCE, CMD_READ_CONT,
    CMD_STOP_CONT, CMD_REG_READ, CMD_REG_WRITE, CMD_CAL_SYS_OFS,
    CMD_CAL_SYS_GAIN, CMD_CAL_SELF_OFS, CMD_NONE
  } cmd_t;

  typedef enum logic [1:0] {
    CAL_SYS_OFFSET, CAL_SYS_GAIN, CAL_SELF_OFFSET
  } cal_kind_t;

  // Maps a first command byte to its command; anything else is CMD_NONE.
  function automatic cmd_t decode_command(input logic [7:0] b);
    cmd_t c;
    c = CMD_NONE;
    if (b[7:1] == OP_WAKE) c = CMD_WAKE;
    else if (b[7:1] == OP_SLEEP) c = CMD_SLEEP;
    else if (b[7:1] == OP_SYNC) c = CMD_SYNC;
    else if (b[7:1] == OP_RESET) c = CMD_RESET;
    else if (b[7:1] == OP_READ_ONCE) c = CMD_READ_ONCE;
    else if (b[7:1] == OP_READ_CONT) c = CMD_READ_CONT;
    else if (b[7:1] == OP_STOP_CONT) c = CMD_STOP_CONT;
    else if (b[7:4] == OP_REG_READ) c = CMD_REG_READ;
    else if (b[7:4] == OP_REG_WRITE) c = CMD_REG_WRITE;
    else if (b == OP_CAL_SYS_OFS) c = CMD_CAL_SYS_OFS;
    else if (b == OP_CAL_SYS_GAIN) c = CMD_CAL_SYS_GAIN;
    else if (b == OP_CAL_SELF_OFS) c = CMD_CAL_SELF_OFS;
    return c;
  endfunction

endpackage

// ### adc_link_if.sv
// Serial link between the converter command decoder and its host.
`timescale 1ns/1ps
`default_nettype none
interface adc_link_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  logic conversion_ready_n;

  modport device (input sclk, input cs_n, input mosi, output miso, output conversion_ready_n);
  modport host (output sclk, output cs_n, output mosi, input miso, input conversion_ready_n);
endinterface
`default_nettype wire

// ### link_sync.sv
// Two-flop synchroniser for a group of level inputs.
`timescale 1ns/1ps
`default_nettype none
module link_sync #(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             i_clk,
  input  wire logic             i_srst,
  input  wire logic [WIDTH-1:0] i_d,
  output logic      [WIDTH-1:0] o_q
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_q;

  // First stage feeds only the second stage; reset loads the idle levels so no false edge follows.
  always_comb begin
    next_stage1 = i_srst ? RST_VAL : i_d;
    next_q      = i_srst ? RST_VAL : stage1;
  end

  // Register both stages.
  always_ff @(posedge i_clk) begin
    stage1 <= next_stage1;
    o_q    <= next_q;
  end
endmodule
`default_nettype wire

// ### adc_cmd_host.sv
// Host end of the serial link: byte transmitter with clock divider and wait rules.
`timescale 1ns/1ps
`default_nettype none
module adc_cmd_host
  import adc_cmd_pkg::*;
#(
  parameter int HOLD_POWERUP = POWERUP_CYCLES_DEFAULT,
  parameter int HOLD_SOFT    = SOFT_RESET_CYCLES_DEFAULT,
  parameter int SCLK_HALF    = SCLK_HALF_CYCLES_DEFAULT
) (
  input  wire logic        i_clk,
  input  wire logic        i_srst,
  adc_link_if.host         lnk,
  input  wire logic        i_tx_valid,
  input  wire logic [7:0]  i_tx_byte,
  input  wire logic        i_tx_last,
  output logic             o_tx_ready,
  output logic             o_rx_valid,
  output logic [7:0]       o_rx_byte,
  output logic             o_data_ready
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (SCLK_HALF < 6 || SCLK_HALF > 31) begin : g_bad_half
    $error("SCLK_HALF must be 6 to 31");
  end
  if (HOLD_POWERUP < 1 || HOLD_SOFT < 1 || HOLD_POWERUP >= 2 ** HOLD_W
      || HOLD_SOFT >= 2 ** HOLD_W) begin : g_bad_hold
    $error("hold counts out of range");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {HP_IDLE, HP_HELD, HP_LOW, HP_HIGH, HP_END} host_phase_t;

  typedef struct packed {
    host_phase_t        phase;
    logic [4:0]         cnt;
    logic [2:0]         bitn;
    logic [7:0]         sh;
    logic [7:0]         rx;
    logic               last;
    logic               soft_rst;
    logic [HOLD_W-1:0]  wait_cnt;
    logic               sclk;
    logic               cs_n;
    logic               rx_valid;
    logic               rdy_prev;
    logic               rdy_seen;
    logic               data_ready;
    logic               tx_ready;
  } host_state_t;

  host_state_t s;
  host_state_t n;
  logic [1:0]  pins_s;

  // Bring device outputs into the clock domain.
  link_sync #(.WIDTH(2), .RST_VAL(2'h1)) u_sync (
    .i_clk  (i_clk),
    .i_srst (i_srst),
    .i_d    ({lnk.miso, lnk.conversion_ready_n}),
    .o_q    (pins_s)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic accept;
    logic start_cont;
    start_cont = (i_tx_byte[7:1] == OP_READ_CONT);
    // A start-continuous byte waits until ready has fallen.
    accept = i_tx_valid && s.tx_ready && !(start_cont && !s.rdy_seen);
    n = s;
    n.rx_valid   = 1'b0;
    n.rdy_prev   = pins_s[0];
    n.data_ready = s.rdy_prev & ~pins_s[0];
    if (s.rdy_prev & ~pins_s[0]) n.rdy_seen = 1'b1;
    if (s.wait_cnt != '0) n.wait_cnt = s.wait_cnt - 1'b1;
    case (s.phase)
      HP_IDLE, HP_HELD: begin
        if (accept && i_tx_byte != OP_RESTRICTED) begin
          n.phase = HP_LOW;
          n.cs_n  = 1'b0;
          n.sh    = i_tx_byte;
          n.last  = i_tx_last;
          n.bitn  = 3'd0;
          n.cnt   = 5'(SCLK_HALF);
          n.soft_rst = (i_tx_byte[7:1] == OP_RESET);
          // A ready fall seen in this very cycle still counts for the next start.
          if (start_cont) n.rdy_seen = s.rdy_prev & ~pins_s[0];
        end else if (accept && s.phase == HP_HELD && i_tx_last) begin
          // A dropped restricted byte that ends the frame still closes select.
          n.phase = HP_END;
          n.cnt   = 5'(SCLK_HALF);
        end
      end
      HP_LOW: begin
        n.cnt = s.cnt - 5'd1;
        if (s.cnt == 5'd1) begin
          n.sclk  = 1'b1;
          n.rx    = {s.rx[6:0], pins_s[1]};
          n.cnt   = 5'(SCLK_HALF);
          n.phase = HP_HIGH;
        end
      end
      HP_HIGH: begin
        n.cnt = s.cnt - 5'd1;
        if (s.cnt == 5'd1) begin
          n.sclk = 1'b0;
          n.bitn = s.bitn + 3'd1;
          n.sh   = {s.sh[6:0], 1'b1};
          n.cnt  = 5'(SCLK_HALF);
          n.phase = HP_LOW;
          if (s.bitn == 3'd7) begin
            n.rx_valid = 1'b1;
            n.phase    = s.last ? HP_END : HP_HELD;
            // The soft reset command blocks traffic for the hold time.
            if (s.soft_rst) n.wait_cnt = HOLD_W'(HOLD_SOFT);
          end
        end
      end
      HP_END: begin
        n.cnt = s.cnt - 5'd1;
        if (s.cnt == 5'd1) begin
          n.cs_n  = 1'b1;
          n.phase = HP_IDLE;
        end
      end
      default: n.phase = HP_IDLE;
    endcase
    n.tx_ready = (n.phase == HP_IDLE || n.phase == HP_HELD) && n.wait_cnt == '0;
    if (i_srst) begin
      n = '0;
      n.phase    = HP_IDLE;
      n.cs_n     = 1'b1;
      n.sh       = NO_OPERATION_BYTE;
      n.rdy_prev = 1'b1;
      n.wait_cnt = HOLD_W'(HOLD_POWERUP);
    end
  end

  // Register the state.
  always_ff @(posedge i_clk) begin
    s <= n;
  end

  // Outputs straight from the state flops.
  assign lnk.sclk     = s.sclk;
  assign lnk.cs_n     = s.cs_n;
  assign lnk.mosi     = s.sh[7];
  assign o_tx_ready   = s.tx_ready;
  assign o_rx_valid   = s.rx_valid;
  assign o_rx_byte    = s.rx;
  assign o_data_ready = s.data_ready;

endmodule
`default_nettype wire

// ### adc_cmd_link_assertions.sv
// Concurrent checks on the serial link between the host and converter ends.
`timescale 1ns/1ps
`default_nettype none
module adc_cmd_link_assertions (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic conversion_ready_n
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);

  // ------------------------------------------------------------
  // Helper logic
  // ------------------------------------------------------------
  logic       sclk_q;
  logic [7:0] rises;
  logic [7:0] next_rises;

  // Counts serial clock rises inside a frame; a frame must hold whole bytes.
  always_comb begin
    next_rises = rises;
    if (cs_n) begin
      next_rises = 8'h00;
    end else if (sclk && !sclk_q) begin
      next_rises = rises + 8'h01;
    end
  end

  // Registers the rise count and the delayed serial clock.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      rises  <= 8'h00;
      sclk_q <= 1'b0;
    end else begin
      rises  <= next_rises;
      sclk_q <= sclk;
    end
  end

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  sequence s_high_half;
    sclk [*8] ##1 !sclk;
  endsequence
  sequence s_low_half;
    !sclk [*8];
  endsequence

  sclk_idle_low_a: assert property (cs_n |-> !sclk)
    else $error("serial clock not low outside a frame");
  mosi_hold_a: assert property (sclk && $past(sclk) |-> $stable(mosi))
    else $error("data input changed while serial clock high");
  high_width_a: assert property ($rose(sclk) |-> s_high_half)
    else $error("serial clock high phase has wrong length");
  low_width_a: assert property ($fell(sclk) |-> s_low_half)
    else $error("serial clock low phase too short");
  cs_setup_a: assert property ($fell(cs_n) |-> s_low_half ##1 sclk)
    else $error("first serial clock rise not eight cycles after select");
  ready_clear_a: assert property ($rose(sclk) && !conversion_ready_n |-> ##[1:6] conversion_ready_n)
    else $error("conversion ready not released after clock rise");
  miso_hold_a: assert property ((!cs_n && sclk) [*5] |-> $stable(miso))
    else $error("data output changed while serial clock high");
  whole_bytes_a: assert property ($rose(cs_n) |-> rises[2:0] == 3'h0)
    else $error("frame ended inside a byte");
endmodule
`default_nettype wire

// ### adc_spi_command_decoder_tb.sv
// Self-checking bench joining host and converter ends over the serial link.
`timescale 1ns/1ps
`default_nettype none
module adc_spi_command_decoder_tb;
  import adc_cmd_pkg::*;
  logic                   i_clk = 1'b0;
  logic                   i_srst = 1'b1;
  logic                   tx_valid = 1'b0;
  logic                   tx_last = 1'b0;
  logic [7:0]             tx_byte = 8'hFF;
  logic                   res_valid = 1'b0;
  logic                   cal_done = 1'b0;
  logic [23:0]            res = 24'h000000;
  logic                   tx_ready, rx_valid, data_ready, sleep, restart, hold, cal_start, cont;
  logic [7:0]             rx_byte;
  logic [1:0]             cal_kind;
  logic [REG_COUNT*8-1:0] regs, snap;
  logic [7:0]             rxq[$];
  logic [7:0]             exp6[6];
  int                     error_cnt = 0;
  int                     total_checks = 0;
  int                     cyc = 0;
  int                     restarts = 0;
  int                     cal_starts = 0;
  int                     holds = 0;
  int                     readies = 0;
  int                     base, h;

  always #12.5 i_clk = ~i_clk;

  adc_link_if lnk();
  adc_cmd_host #(.HOLD_POWERUP(20), .HOLD_SOFT(20)) u_adc_cmd_host (.i_clk(i_clk),
    .i_srst(i_srst), .lnk(lnk), .i_tx_valid(tx_valid), .i_tx_byte(tx_byte),
    .i_tx_last(tx_last), .o_tx_ready(tx_ready), .o_rx_valid(rx_valid),
    .o_rx_byte(rx_byte), .o_data_ready(data_ready));
  adc_cmd_device #(.HOLD_POWERUP(20), .HOLD_SOFT(20)) u_adc_cmd_device (.i_clk(i_clk),
    .i_srst(i_srst), .lnk(lnk), .i_result_valid(res_valid), .i_result(res),
    .i_cal_done(cal_done), .i_cal_coeff(res), .o_sleep(sleep), .o_filter_restart(restart),
    .o_reset_hold(hold), .o_cal_start(cal_start), .o_cal_kind(cal_kind),
    .o_continuous(cont), .o_reg_file(regs));
  adc_cmd_link_assertions u_adc_cmd_link_assertions (.i_clk(i_clk), .i_srst(i_srst),
    .sclk(lnk.sclk), .cs_n(lnk.cs_n), .mosi(lnk.mosi), .miso(lnk.miso),
    .conversion_ready_n(lnk.conversion_ready_n));

  // Collects received bytes, counts pulses and cuts a hang short, away from the launching edge.
  always @(negedge i_clk) begin
    cyc++;
    if (data_ready === 1'b1) readies++;
    if (rx_valid === 1'b1) rxq.push_back(rx_byte);
    if (restart === 1'b1) restarts++;
    if (cal_start === 1'b1) cal_starts++;
    if (hold === 1'b1) holds++;
    if (cyc == 30000) begin
      error_cnt++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [127:0] e, input logic [127:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %0h seen %0h", n, e, g);
    end
  endtask

  // Sends one frame of bytes through the host and waits for select to return high.
  task automatic frame(input logic [7:0] q[$]);
    int n;
    rxq.delete();
    foreach (q[i]) begin
      for (n = 0; n < 3000 && tx_ready !== 1'b1; n++) @(posedge i_clk) #2;
      tx_valid = 1'b1;
      tx_byte = q[i];
      tx_last = (i == q.size() - 1);
      @(posedge i_clk) #2;
      tx_valid = 1'b0;
    end
    repeat (2) @(posedge i_clk) #2;
    for (n = 0; n < 400 && lnk.cs_n !== 1'b1; n++) @(posedge i_clk) #2;
    repeat (8) @(posedge i_clk) #2;
  endtask

  // Reports a finished conversion with the given value.
  task automatic result(input logic [23:0] v);
    int   r;
    logic was_high;
    r = readies;
    // A ready flag that is already low gives the host no new fall.
    was_high = lnk.conversion_ready_n;
    res = v;
    res_valid = 1'b1;
    @(posedge i_clk) #2;
    res_valid = 1'b0;
    repeat (4) @(posedge i_clk) #2;
    chk("ready_n", 1'b0, lnk.conversion_ready_n);
    chk("data_ready", r + was_high, readies);
  endtask

  initial begin
    repeat (5) @(posedge i_clk) #2;
    i_srst = 1'b0;
    repeat (2) @(posedge i_clk) #2;
    chk("powerup_hold", 1'b1, hold);
    chk("powerup_ready", 1'b0, tx_ready);
    chk("cont_reset", 1'b1, cont);
    frame('{8'h4E, 8'h02, 8'hA1, 8'hB2, 8'hC3});
    exp6 = '{8'hA1, 8'hB2, 8'hC3, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 3; i++) chk("reg_write", exp6[i], regs[8*((14+i)%16) +: 8]);
    frame('{8'h2E, 8'h02, 8'hFF, 8'hFF, 8'hFF});
    for (int i = 0; i < 3; i++) chk("reg_read", exp6[i], rxq[i+2]);
    snap = regs;
    frame('{8'hF0, 8'hF1});
    chk("restricted_end", 1'b1, lnk.cs_n);
    chk("unknown_byte", snap, regs);
    for (int b = 0; b < 2; b++) begin
      frame('{8'h02 | b[7:0]});
      chk("sleep_pending", 1'b0, sleep);
      result(24'h000000);
      chk("sleep", 1'b1, sleep);
      frame('{8'h00 | b[7:0]});
      chk("wake", 1'b0, sleep);
      h = restarts;
      frame('{8'h04 | b[7:0], 8'h05});
      chk("sync", h + 1, restarts);
    end
    frame('{8'h05, 8'h13, 8'hFF});
    chk("sync_broken", h + 1, restarts);
    for (int k = 0; k < 3; k++) begin
      h = cal_starts;
      frame('{8'h60 + k[7:0]});
      chk("cal_start", h + 1, cal_starts);
      chk("cal_kind", k[1:0], cal_kind);
      res = 24'h302010 + k[23:0];
      cal_done = 1'b1;
      @(posedge i_clk) #2;
      cal_done = 1'b0;
      repeat (3) @(posedge i_clk) #2;
      base = (k == 1) ? GAIN_REG_BASE : OFFSET_REG_BASE;
      chk("cal_coeff", res, regs[8*base +: 24]);
    end
    frame('{8'h16});
    chk("stop_pending", 1'b1, cont);
    result(24'hABCDEF);
    chk("stopped", 1'b0, cont);
    result(24'h123456);
    frame('{8'h13, 8'hFF, 8'hFF, 8'hFF});
    exp6 = '{8'h12, 8'h34, 8'h56, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 3; i++) chk("read_once", exp6[i], rxq[i+1]);
    frame('{8'h14});
    chk("start_pending", 1'b0, cont);
    result(24'h654321);
    chk("started", 1'b1, cont);
    frame('{8'hFF, 8'hFF, 8'h12, 8'hFF, 8'hFF, 8'hFF});
    exp6 = '{8'h65, 8'h43, 8'h21, 8'h65, 8'h43, 8'h21};
    for (int i = 0; i < 6; i++) chk("cont_read", exp6[i], rxq[i]);
    h = holds;
    frame('{8'h07});
    chk("soft_wait", 1'b0, tx_ready);
    repeat (30) @(posedge i_clk) #2;
    chk("soft_hold", 1'b1, holds > h);
    chk("soft_regs", 128'h0, regs);
    chk("soft_mode", 1'b1, cont);
    frame('{8'h41, 8'h00, 8'h5A});
    chk("after_reset", 8'h5A, regs[15:8]);
    complete_run();
  end
endmodule
`default_nettype wire
